// File: pkg/ddrtx_pkg.sv
/*
 * Shared constants and types for the DDR transmit parallel capture port.
 * Assumes a single 100 MHz core clock; the link clocks are sampled as data.
 */
package ddrtx_pkg;

   // Bus and channel geometry.
   localparam int NUM_PAIRS = 4;
   localparam int NUM_CH = 8;
   localparam int BUS_W = 10;
   localparam int LANE_W = 5;
   localparam int DATA_W = 8;
   localparam int MUX_K_BIT = 8;
   localparam int LANE_K_BIT = 3;
   localparam int LANE_TOP_BIT = 4;

   // Path buffering and serial pacing.
   localparam int FIFO_DEPTH = 16;
   localparam int CLK_MHZ = 100;
   localparam int SERIAL_MHZ = 25;
   localparam int BIT_DIV = CLK_MHZ / SERIAL_MHZ;
   localparam int DIV_W = 4;
   localparam int CNT_W = 4;
   localparam logic [CNT_W-1:0] BITS_PER_WORD = 4'h0 + CNT_W'(BUS_W);
   localparam logic SERIAL_STATIC = 1'b0;

   // Reference clock range the other party must respect.
   localparam int REFERENCE_INPUT_CLOCK_MIN_MHZ = 100;
   localparam int REFERENCE_INPUT_CLOCK_MAX_MHZ = 130;

   // Register port map.
   localparam int REG_ADDR_W = 4;
   localparam logic [REG_ADDR_W-1:0] REG_CTRL = 4'h0;
   localparam logic [REG_ADDR_W-1:0] REG_STATUS = 4'h4;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam int STAT_OVR_LSB = 0;
   localparam int STAT_RDY_LSB = 4;

   typedef enum logic [0:0]
   {
      DDRTX_PH_LOW = 1'b0,
      DDRTX_PH_HIGH = 1'b1
   } ddrtx_phase_t;

   typedef struct packed
   {
      logic k;
      logic [BUS_W-1:0] word;
   } ddrtx_char_t;

   typedef struct packed
   {
      ddrtx_char_t late;
      ddrtx_char_t early;
   } ddrtx_pair_t;

   typedef struct packed
   {
      logic mux_mode;
      logic indep;
      logic encode;
      logic wrap;
   } ddrtx_mode_t;

endpackage

// File: verilog/ddrtx_fifo.sv
/*
 * Synchronous FIFO with valid/ready on both sides.
 * Assumes one clock; DEPTH is a power of two.
 */
`timescale 1ns/10ps
module ddrtx_fifo #(
   parameter int WIDTH = 22,
   parameter int DEPTH = 16
)
(
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_b_i,
   // Filling side.
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   // Draining side.
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_ptr;
   logic [AW:0] rd_ptr;
   wire do_push;
   wire do_pop;
   wire is_full;
   wire is_empty;

   assign is_empty = (wr_ptr == rd_ptr);
   assign is_full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
   assign in_ready_o = ~is_full;
   assign out_valid_o = ~is_empty;
   assign do_push = in_valid_i & ~is_full;
   assign do_pop = out_ready_i & ~is_empty;
   assign out_data_o = mem[rd_ptr[AW-1:0]];

   always_ff @(posedge clk_i)
   begin
      if (do_push)
      begin
         mem[wr_ptr[AW-1:0]] <= in_data_i;
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end
      else
      begin
         wr_ptr <= wr_ptr + (AW+1)'(do_push);
         rd_ptr <= rd_ptr + (AW+1)'(do_pop);
      end
   end

endmodule

// File: verilog/ddrtx_capture.sv
/*
 * Transmit parallel capture port: samples four DDR pair buses, assembles
 * channel words, buffers them and serialises each channel bit 0 first.
 * Assumes the link clocks and buses are asynchronous pins sampled by clk_i.
 */
// How it works
// - Each serial output is held static while the wrap pin or that channel's loopback bit is set.
// - In synchronized modes all four pair buses are taken on both edges of the shared clock.
// - In independent mode the shared clock takes only the A/B pair bus, on both edges.
// - In independent mode each other pair bus is taken on both edges of its own pair clock.
// - Each word goes out on the serial line with bit 0 first.
// - In multiplexed mode the falling edge carries the earlier channel and the rising the later.
// - In nibble mode the low half comes at the falling edge and the high half at the next rising.
// - In nibble mode the earlier channel uses bus bits 4 to 0 and the later bits 9 to 5.
// - In nibble mode with the encoder on, bus bit 3 is the earlier channel's K flag.
// - In multiplexed mode bit 8 is the ninth word bit without encoder and the K flag with it.
// - With the encoder on and bit 8 high, data bits 7 to 0 are sent on as a K character.
// - In nibble mode bit 8 is the later channel's bits 3 and 8, or its K flag with encoder on.
// - In multiplexed mode a transfer is 8 data bits for the encoder or a 10-bit coded word.
`timescale 1ns/10ps
module ddrtx_capture
(
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_b_i,
   // Link clocks.
   input wire logic shared_tx_clock_i,
   input wire logic pair_cd_tx_clock_i,
   input wire logic pair_ef_tx_clock_i,
   input wire logic pair_gh_tx_clock_i,
   // Link data buses.
   input wire logic [ddrtx_pkg::BUS_W-1:0] pair_ab_tx_bus_i,
   input wire logic [ddrtx_pkg::BUS_W-1:0] pair_cd_tx_bus_i,
   input wire logic [ddrtx_pkg::BUS_W-1:0] pair_ef_tx_bus_i,
   input wire logic [ddrtx_pkg::BUS_W-1:0] pair_gh_tx_bus_i,
   // Mode pins.
   input wire logic mux_mode_i,
   input wire logic indep_mode_i,
   input wire logic encoder_select_i,
   input wire logic serial_wrap_select_pin_i,
   // Register port.
   input wire logic [ddrtx_pkg::REG_ADDR_W-1:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [31:0] reg_rdata_o,
   // Serial, character and pair ready outputs.
   output logic [ddrtx_pkg::NUM_CH-1:0] tx_serial_o,
   output ddrtx_pkg::ddrtx_char_t [ddrtx_pkg::NUM_CH-1:0] tx_char_o,
   output logic [ddrtx_pkg::NUM_CH-1:0] tx_char_load_o,
   output logic [ddrtx_pkg::NUM_PAIRS-1:0] pair_ready_o
);
   import ddrtx_pkg::*;

   logic [NUM_PAIRS-1:0] lclk_s1;
   logic [NUM_PAIRS-1:0] lclk_s2;
   logic [NUM_PAIRS-1:0][BUS_W-1:0] bus_s1;
   logic [NUM_PAIRS-1:0][BUS_W-1:0] bus_s2;
   ddrtx_mode_t mode_s1;
   ddrtx_mode_t mode;
   logic [NUM_CH-1:0] loop_bits;
   logic [NUM_PAIRS-1:0] overrun;
   logic [NUM_PAIRS-1:0] overrun_set;
   logic [DIV_W-1:0] div_cnt;
   logic bit_en;
   logic [31:0] next_rdata;
   wire [NUM_PAIRS-1:0] raw_clk;
   wire [NUM_PAIRS-1:0][BUS_W-1:0] raw_bus;
   wire ddrtx_mode_t raw_mode;
   wire wr_ctrl;
   wire wr_status;
   wire div_wrap;

   // Forms one channel character from its raw bits.
   function automatic ddrtx_char_t form_char(input logic enc, input logic k,
                                             input logic [DATA_W-1:0] data,
                                             input logic [BUS_W-1:0] raw);
      ddrtx_char_t c;
      c.k = enc & k;
      c.word = enc ? {1'b0, k, data} : raw;
      return c;
   endfunction

   // Packs the four data bits of a lane half, leaving out the K position.
   function automatic logic [DATA_W/2-1:0] lane_data(input logic [LANE_W-1:0] lane);
      return {lane[LANE_TOP_BIT], lane[LANE_K_BIT-1:0]};
   endfunction

   // Builds a channel from its two lane halves in nibble mode.
   function automatic ddrtx_char_t nibble_char(input logic enc, input logic [LANE_W-1:0] lo,
                                               input logic [LANE_W-1:0] hi);
      return form_char(enc, hi[LANE_K_BIT], {lane_data(hi), lane_data(lo)}, {hi, lo});
   endfunction

   // Joins the falling and rising bus samples into one pair record.
   function automatic ddrtx_pair_t build_pair(input ddrtx_mode_t m,
                                              input logic [BUS_W-1:0] fall_bus,
                                              input logic [BUS_W-1:0] rise_bus);
      ddrtx_pair_t r;
      if (m.mux_mode)
      begin
         r.early = form_char(m.encode, fall_bus[MUX_K_BIT], fall_bus[DATA_W-1:0],
                             fall_bus);
         r.late = form_char(m.encode, rise_bus[MUX_K_BIT], rise_bus[DATA_W-1:0],
                            rise_bus);
      end
      else
      begin
         r.early = nibble_char(m.encode, fall_bus[LANE_W-1:0], rise_bus[LANE_W-1:0]);
         r.late = nibble_char(m.encode, fall_bus[BUS_W-1:LANE_W],
                              rise_bus[BUS_W-1:LANE_W]);
      end
      return r;
   endfunction

   assign raw_clk = {pair_gh_tx_clock_i, pair_ef_tx_clock_i, pair_cd_tx_clock_i,
                     shared_tx_clock_i};
   assign raw_bus = {pair_gh_tx_bus_i, pair_ef_tx_bus_i, pair_cd_tx_bus_i, pair_ab_tx_bus_i};
   assign raw_mode = '{mux_mode: mux_mode_i, indep: indep_mode_i,
                       encode: encoder_select_i, wrap: serial_wrap_select_pin_i};

   // Two-stage synchronisers for every link clock, link bus and mode pin.
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         lclk_s1 <= '1;
         lclk_s2 <= '1;
         bus_s1 <= '0;
         bus_s2 <= '0;
         mode_s1 <= '0;
         mode <= '0;
      end
      else
      begin
         lclk_s1 <= raw_clk;
         lclk_s2 <= lclk_s1;
         bus_s1 <= raw_bus;
         bus_s2 <= bus_s1;
         mode_s1 <= raw_mode;
         mode <= mode_s1;
      end
   end

   // Serial bit rate enable.
   assign div_wrap = (div_cnt == DIV_W'(BIT_DIV - 1));

   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         div_cnt <= '0;
         bit_en <= 1'b0;
      end
      else
      begin
         div_cnt <= div_wrap ? '0 : div_cnt + DIV_W'(1);
         bit_en <= div_wrap;
      end
   end

   for (genvar p = 0; p < NUM_PAIRS; p++)
   begin : g_pair
      logic sel_clk;
      logic clk_prev;
      logic rise;
      logic fall;
      logic take;
      ddrtx_phase_t phase;
      ddrtx_phase_t next_phase;
      logic [BUS_W-1:0] fall_bus;
      ddrtx_pair_t rec;
      ddrtx_pair_t push_rec;
      logic push;
      logic in_ready;
      ddrtx_pair_t fifo_out;
      logic fifo_valid;
      logic load;
      logic [BUS_W-1:0] sh_e;
      logic [BUS_W-1:0] sh_l;
      logic [CNT_W-1:0] bits_left;
      logic busy;
      logic ser_e;
      logic ser_l;
      logic next_ser_e;
      logic next_ser_l;
      ddrtx_char_t char_e;
      ddrtx_char_t char_l;
      logic load_q;

      assign sel_clk = (mode.indep && p != 0) ? lclk_s2[p] : lclk_s2[0];
      assign rise = sel_clk & ~clk_prev;
      assign fall = ~sel_clk & clk_prev;
      assign take = rise && (phase == DDRTX_PH_HIGH);
      assign next_phase = fall ? DDRTX_PH_HIGH : (rise ? DDRTX_PH_LOW : phase);
      assign rec = build_pair(mode, fall_bus, bus_s2[p]);

      always_ff @(posedge clk_i or negedge rst_b_i)
      begin
         if (!rst_b_i)
         begin
            clk_prev <= 1'b1;
            phase <= DDRTX_PH_LOW;
            fall_bus <= '0;
            push <= 1'b0;
            push_rec <= '0;
         end
         else
         begin
            clk_prev <= sel_clk;
            phase <= next_phase;
            fall_bus <= fall ? bus_s2[p] : fall_bus;
            push <= take;
            push_rec <= take ? rec : push_rec;
         end
      end

      ddrtx_fifo #(
         .WIDTH($bits(ddrtx_pair_t)),
         .DEPTH(FIFO_DEPTH)
      ) u_fifo (
         .clk_i(clk_i),
         .rst_b_i(rst_b_i),
         .in_valid_i(push),
         .in_ready_o(in_ready),
         .in_data_i(push_rec),
         .out_valid_o(fifo_valid),
         .out_ready_i(~busy),
         .out_data_o(fifo_out)
      );

      assign load = ~busy & fifo_valid;
      assign overrun_set[p] = push & ~in_ready;
      assign pair_ready_o[p] = in_ready;
      assign next_ser_e = (mode.wrap | loop_bits[2*p] | ~busy) ? SERIAL_STATIC : sh_e[0];
      assign next_ser_l = (mode.wrap | loop_bits[2*p+1] | ~busy) ? SERIAL_STATIC
                                                                  : sh_l[0];

      always_ff @(posedge clk_i or negedge rst_b_i)
      begin
         if (!rst_b_i)
         begin
            sh_e <= '0;
            sh_l <= '0;
            bits_left <= '0;
            busy <= 1'b0;
         end
         else if (load)
         begin
            sh_e <= fifo_out.early.word;
            sh_l <= fifo_out.late.word;
            bits_left <= BITS_PER_WORD;
            busy <= 1'b1;
         end
         else if (bit_en && busy)
         begin
            sh_e <= sh_e >> 1;
            sh_l <= sh_l >> 1;
            bits_left <= bits_left - CNT_W'(1);
            busy <= (bits_left != CNT_W'(1));
         end
      end

      always_ff @(posedge clk_i or negedge rst_b_i)
      begin
         if (!rst_b_i)
         begin
            ser_e <= SERIAL_STATIC;
            ser_l <= SERIAL_STATIC;
            char_e <= '0;
            char_l <= '0;
            load_q <= 1'b0;
         end
         else
         begin
            ser_e <= (bit_en | mode.wrap | loop_bits[2*p]) ? next_ser_e : ser_e;
            ser_l <= (bit_en | mode.wrap | loop_bits[2*p+1]) ? next_ser_l : ser_l;
            char_e <= load ? fifo_out.early : char_e;
            char_l <= load ? fifo_out.late : char_l;
            load_q <= load;
         end
      end

      assign tx_serial_o[2*p] = ser_e;
      assign tx_serial_o[2*p+1] = ser_l;
      assign tx_char_o[2*p] = char_e;
      assign tx_char_o[2*p+1] = char_l;
      assign tx_char_load_o[2*p] = load_q;
      assign tx_char_load_o[2*p+1] = load_q;
   end

   // Register port: loopback control and sticky overrun status.
   assign wr_ctrl = reg_wr_i && (reg_addr_i == REG_CTRL);
   assign wr_status = reg_wr_i && (reg_addr_i == REG_STATUS);

   always_comb
   begin
      next_rdata = '0;
      if (reg_rd_i && reg_addr_i == REG_CTRL)
      begin
         next_rdata[NUM_CH-1:0] = loop_bits;
      end
      else if (reg_rd_i && reg_addr_i == REG_STATUS)
      begin
         next_rdata[STAT_OVR_LSB +: NUM_PAIRS] = overrun;
         next_rdata[STAT_RDY_LSB +: NUM_PAIRS] = pair_ready_o;
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         loop_bits <= CTRL_RESET[NUM_CH-1:0];
         overrun <= '0;
         reg_rdata_o <= '0;
      end
      else
      begin
         loop_bits <= wr_ctrl ? reg_wdata_i[NUM_CH-1:0] : loop_bits;
         overrun <= (overrun & ~(wr_status ? reg_wdata_i[STAT_OVR_LSB +: NUM_PAIRS] : '0))
                    | overrun_set;
         reg_rdata_o <= next_rdata;
      end
   end

endmodule

// File: tb/ddrtx_capture_assertions.sv
/*
 * Pin-level checks on the transmit capture port.
 * Assumes it is bound to the capture port and sees only its ports.
 */
`timescale 1ns/10ps
module ddrtx_capture_checker
(
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_b_i,
   // Watched inputs.
   input wire logic encoder_select_i,
   input wire logic serial_wrap_select_pin_i,
   input wire logic [ddrtx_pkg::REG_ADDR_W-1:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   // Watched outputs.
   input wire logic [31:0] reg_rdata_o,
   input wire logic [ddrtx_pkg::NUM_CH-1:0] tx_serial_o,
   input wire ddrtx_pkg::ddrtx_char_t [ddrtx_pkg::NUM_CH-1:0] tx_char_o,
   input wire logic [ddrtx_pkg::NUM_CH-1:0] tx_char_load_o,
   input wire logic [ddrtx_pkg::NUM_PAIRS-1:0] pair_ready_o
);
   import ddrtx_pkg::*;
   logic [NUM_CH-1:0] ctrl_sh;
   always_ff @(posedge clk_i or negedge rst_b_i)
      if (!rst_b_i)
         ctrl_sh <= '0;
      else if (reg_wr_i && reg_addr_i == REG_CTRL)
         ctrl_sh <= reg_wdata_i[NUM_CH-1:0];
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_b_i);
   sequence s_load_a;
      tx_char_load_o[0] && !ctrl_sh[0] && !serial_wrap_select_pin_i;
   endsequence
   a_wrap_static: assert property (serial_wrap_select_pin_i [*6] |-> tx_serial_o == '0)
      else $error("serial moved while wrapped");
   a_loop_static: assert property ((tx_serial_o & ctrl_sh & $past(ctrl_sh, 2)) == '0)
      else $error("serial moved in loopback");
   a_lsb_first: assert property (s_load_a ##0 tx_char_o[0].word[0] |-> ##[1:8] tx_serial_o[0])
      else $error("bit 0 not sent first");
   a_enc_word: assert property (tx_char_load_o[0] |-> (encoder_select_i ?
      tx_char_o[0].word[9:8] == {1'b0, tx_char_o[0].k} : !tx_char_o[0].k))
      else $error("character flag wrong");
   a_pair_load: assert property ((((tx_char_load_o >> 1) ^ tx_char_load_o) & 8'h55) == 8'h00)
      else $error("pair channels loaded apart");
   a_load_gap: assert property ($rose(tx_char_load_o[0]) |=> !tx_char_load_o[0] [*8])
      else $error("load during serial word");
   a_rd_idle: assert property (!reg_rd_i |=> reg_rdata_o == '0)
      else $error("read data without read");
   a_ctrl_read: assert property (reg_rd_i && reg_addr_i == REG_CTRL
      |=> reg_rdata_o[7:0] == $past(ctrl_sh))
      else $error("control readback wrong");
   a_stat_ready: assert property (reg_rd_i && reg_addr_i == REG_STATUS && $stable(pair_ready_o)
      |=> reg_rdata_o[7:4] == $past(pair_ready_o))
      else $error("status ready field wrong");
   a_unmapped_rd: assert property (reg_rd_i && reg_addr_i != REG_CTRL && reg_addr_i != REG_STATUS
      |=> reg_rdata_o == '0)
      else $error("unmapped read not zero");
   a_reset_quiet: assert property (!$past(rst_b_i) |-> tx_char_load_o == '0 && tx_serial_o == '0)
      else $error("activity right after reset");
endmodule
bind ddrtx_capture ddrtx_capture_checker u_chk
(
   .clk_i, .rst_b_i, .encoder_select_i, .serial_wrap_select_pin_i,
   .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
   .tx_serial_o, .tx_char_o, .tx_char_load_o, .pair_ready_o
);

// File: tb/ddrtx_link_model.sv
/*
 * Protocol device model driving one DDR pair bus and its clock.
 * Assumes the capture port samples both pins with its own clock.
 */
`timescale 1ns/10ps
module ddrtx_link_model
(
   // Link pins.
   output logic clk_o,
   output logic [9:0] bus_o
);
   initial
   begin
      clk_o = 1'b1;
      bus_o = 10'h000;
   end
   // One fall then rise transfer; the clock rests high between frames.
   task automatic send(input logic [9:0] lo, hi, input logic run);
      bus_o = lo;
      #31.25;
      clk_o = ~run;
      #31.25;
      bus_o = hi;
      #31.25;
      clk_o = 1'b1;
      #20;
      bus_o = {1'b0, ~hi[8:0]};
      #11.25;
   endtask
endmodule

// File: tb/tb.sv
/*
 * Self-checking bench for the transmit capture port.
 * Assumes the link model and checker files are compiled first.
 */
`timescale 1ns/10ps
module tb;
   import ddrtx_pkg::*;
   logic clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic mux_mode_i = 1'b1;
   logic indep_mode_i = 1'b0;
   logic encoder_select_i = 1'b0;
   logic serial_wrap_select_pin_i = 1'b0;
   logic [REG_ADDR_W-1:0] reg_addr_i = 4'h0;
   logic [31:0] reg_wdata_i = 32'h0000_0000;
   logic reg_wr_i = 1'b0;
   logic reg_rd_i = 1'b0;
   logic [31:0] reg_rdata_o;
   logic [NUM_CH-1:0] tx_serial_o;
   ddrtx_char_t [NUM_CH-1:0] tx_char_o;
   logic [NUM_CH-1:0] tx_char_load_o;
   logic [NUM_PAIRS-1:0] pair_ready_o;
   wire logic ck_ab, ck_cd, ck_ef, ck_gh;
   wire logic [BUS_W-1:0] b_ab, b_cd, b_ef, b_gh;
   ddrtx_char_t got [NUM_CH][$];
   int fails = 0;
   int comparisons = 0;
   int cycles = 0;
   ddrtx_link_model u_ab (.clk_o(ck_ab), .bus_o(b_ab));
   ddrtx_link_model u_cd (.clk_o(ck_cd), .bus_o(b_cd));
   ddrtx_link_model u_ef (.clk_o(ck_ef), .bus_o(b_ef));
   ddrtx_link_model u_gh (.clk_o(ck_gh), .bus_o(b_gh));
   ddrtx_capture u_dut
   (
      .clk_i, .rst_b_i, .shared_tx_clock_i(ck_ab), .pair_cd_tx_clock_i(ck_cd),
      .pair_ef_tx_clock_i(ck_ef), .pair_gh_tx_clock_i(ck_gh), .pair_ab_tx_bus_i(b_ab),
      .pair_cd_tx_bus_i(b_cd), .pair_ef_tx_bus_i(b_ef), .pair_gh_tx_bus_i(b_gh),
      .mux_mode_i, .indep_mode_i, .encoder_select_i, .serial_wrap_select_pin_i,
      .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
      .tx_serial_o, .tx_char_o, .tx_char_load_o, .pair_ready_o
   );
   always #5 clk_i = ~clk_i;
   always @(posedge clk_i)
   begin
      for (int c = 0; c < NUM_CH; c++)
         if (tx_char_load_o[c] === 1'b1)
            got[c].push_back(tx_char_o[c]);
      cycles++;
      if (cycles == 20000)
      begin
         fails++;
         report_and_stop();
      end
   end
   task automatic report_and_stop;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, exp);
      comparisons++;
      if (seen !== exp)
      begin
         fails++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge clk_i);
      reg_wr_i <= 1'b0;
   endtask
   task automatic rdc(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge clk_i);
      reg_rd_i <= 1'b0;
      #1;
      chk(reg_rdata_o & m, e);
   endtask
   task automatic mode(input logic m, e, i);
      @(posedge clk_i);
      mux_mode_i <= m;
      encoder_select_i <= e;
      indep_mode_i <= i;
      repeat (60) @(posedge clk_i);
   endtask
   task automatic meas(output int fa, fb, ca, cb);
      fa = -1;
      fb = -1;
      ca = 0;
      cb = 0;
      for (int i = 0; i < 64; i++)
      begin
         @(posedge clk_i);
         #1;
         ca += int'(tx_serial_o[0] === 1'b1);
         cb += int'(tx_serial_o[1] === 1'b1);
         if (fa < 0 && tx_serial_o[0] === 1'b1)
            fa = i;
         if (fb < 0 && tx_serial_o[1] === 1'b1)
            fb = i;
      end
   endtask
   function automatic ddrtx_char_t exp_char(input logic mux, enc, late, input logic [9:0] f, r);
      logic [9:0] b;
      logic [4:0] lo;
      logic [4:0] hi;
      b = late ? r : f;
      lo = late ? f[9:5] : f[4:0];
      hi = late ? r[9:5] : r[4:0];
      if (!enc)
         return {1'b0, mux ? b : {hi, lo}};
      if (mux)
         return {b[8], 1'b0, b[8], b[7:0]};
      return {hi[3], 1'b0, hi[3], hi[4], hi[2:0], lo[4], lo[2:0]};
   endfunction
   task automatic t_regs;
      rdc(REG_CTRL, CTRL_RESET, 32'hFFFF_FFFF);
      rdc(REG_STATUS, 32'h0000_00F0, 32'hFFFF_FFFF);
      wr(REG_CTRL, 32'h0000_00A5);
      wr(4'h8, 32'h0000_00FF);
      rdc(REG_CTRL, 32'h0000_00A5, 32'hFFFF_FFFF);
      rdc(4'h8, 32'h0000_0000, 32'hFFFF_FFFF);
      wr(REG_CTRL, CTRL_RESET);
   endtask
   task automatic t_map;
      logic [9:0] f [4];
      logic [9:0] r [4];
      for (int m = 0; m < 8; m++)
      begin
         mode(m[0], m[1], m[2]);
         foreach (got[c])
            got[c].delete();
         for (int p = 0; p < 4; p++)
         begin
            f[p] = 10'(m * 37 + p * 113 + 197);
            r[p] = 10'(m * 53 + p * 71 + 410) ^ 10'h2AA;
            f[p][9] = f[p][9] & ~m[1];
            r[p][9] = r[p][9] & ~m[1];
         end
         if (m[2])
         begin
            u_ab.send(f[0], r[0], 1'b1);
            u_cd.send(f[1], r[1], 1'b1);
            u_ef.send(f[2], r[2], 1'b1);
            u_gh.send(f[3], r[3], 1'b1);
         end
         else
            fork
               u_ab.send(f[0], r[0], 1'b1);
               u_cd.send(f[1], r[1], 1'b0);
               u_ef.send(f[2], r[2], 1'b0);
               u_gh.send(f[3], r[3], 1'b0);
            join
         for (int w = 0; w < 300 && got[7].size() == 0; w++)
            @(posedge clk_i);
         repeat (10) @(posedge clk_i);
         for (int c = 0; c < NUM_CH; c++)
         begin
            chk(32'(got[c].size()), 32'h0000_0001);
            chk(32'(got[c][0]), 32'(exp_char(m[0], m[1], c[0], f[c/2], r[c/2])));
         end
      end
   endtask
   task automatic t_serial;
      int fa, fb, ca, cb;
      mode(1'b1, 1'b0, 1'b0);
      u_ab.send(10'h001, 10'h200, 1'b1);
      meas(fa, fb, ca, cb);
      chk(32'(fb - fa), 32'h0000_0024);
      chk(32'(ca + cb), 32'h0000_0008);
   endtask
   task automatic t_wrap;
      int fa, fb, ca, cb;
      wr(REG_CTRL, 32'h0000_0001);
      u_ab.send(10'h3FF, 10'h3FF, 1'b1);
      meas(fa, fb, ca, cb);
      chk(32'(ca), 32'h0000_0000);
      chk(32'(cb), 32'h0000_0028);
      wr(REG_CTRL, CTRL_RESET);
      serial_wrap_select_pin_i <= 1'b1;
      repeat (8) @(posedge clk_i);
      u_ab.send(10'h3FF, 10'h3FF, 1'b1);
      meas(fa, fb, ca, cb);
      chk(32'(ca + cb), 32'h0000_0000);
      serial_wrap_select_pin_i <= 1'b0;
   endtask
   task automatic t_fill;
      logic low_seen;
      low_seen = 1'b0;
      fork
         for (int i = 0; i < 40; i++)
            u_ab.send(10'(i), 10'(~i), 1'b1);
         for (int i = 0; i < 500; i++)
            @(posedge clk_i) low_seen = low_seen | (pair_ready_o[0] === 1'b0);
      join
      chk({31'h0, low_seen}, 32'h0000_0001);
      rdc(REG_STATUS, 32'h0000_0001, 32'h0000_0001);
      repeat (800) @(posedge clk_i);
      rdc(REG_STATUS, 32'h0000_00FF, 32'hFFFF_FFFF);
      wr(REG_STATUS, 32'h0000_000F);
      rdc(REG_STATUS, 32'h0000_00F0, 32'hFFFF_FFFF);
   endtask
   initial
   begin
      repeat (16) @(posedge clk_i);
      rst_b_i <= 1'b1;
      t_regs();
      t_map();
      t_serial();
      t_wrap();
      t_fill();
      report_and_stop();
   end
endmodule
